// ### logic/epd_link_device.sv
// panel controller end: serial receiver, panel setting, power-off order
//
// What this block does
// [R1] transfers only while chip select is low
// [R2] 4-wire: select pin high data, low command
// [R3] reset pin low restores initial state
// [R4] host starts a frame only after it sees busy high; host checks busy only before each frame starts
// [R5] busy low during waveform or sensor activity
// [R6] bus select low 8-bit, high 9-bit
// [R7] mode fixed by pin, serial only
// [R8] data sampled on rising serial clock edge
// [R9] both write and read transfers supported
// [R10] power-down: common, then source, then gate
// [R11] command 00h: two panel bytes, 0fh, 09h
// [R12] first byte bits 7-6 select resolution
// [R13] first byte bit 5 sets power-switch timing
// [R14] bit 3 low: scan gate lines downward
// [R15] bit 3 high: scan gate lines upward
// [R16] bit 2 sets source shift direction
// [R17] bit 1 low turns booster off
// [R18] second byte bit 7 picks waveform source
// [R19] 3-wire: flag bit first, then byte msb-first
// [R20] parameters fill in arrival order per command
// [R21] 4-wire: msb first, select pin held stable
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module epd_link_device
  import epd_link_pkg::*;
#(
  parameter int POWER_STEP_CYCLES = POWER_OFF_STEP_CYCLES,
  parameter logic [7:0] READ_CMD = CMD_READ_DEFAULT
) (
  input wire logic core_clk_in,               // core clock
  input wire logic rst_n_in,                  // sync reset, active low
  epd_link_if.device link,                    // serial link pins
  input wire logic waveform_active_in,        // waveform being output
  input wire logic sensor_active_in,          // sensor access running
  input wire logic power_down_in,             // start power-off, pulse
  input wire logic power_up_in,               // all rails on, pulse
  input wire logic [7:0] rd_byte_in,          // byte returned on reads
  output logic byte_valid_out,                // received byte, pulse
  output logic [7:0] byte_out,                // received byte value
  output logic byte_is_data_out,              // byte was a parameter
  output logic [7:0] command_out,             // current command
  output logic [7:0] panel_first_out,         // panel setting byte 1
  output logic [7:0] panel_second_out,        // panel setting byte 2
  output logic [1:0] resolution_sel_out,      // resolution code
  output logic [7:0] gate_lines_out,          // first resolution figure
  output logic [7:0] source_lines_out,        // second resolution figure
  output logic power_switch_timing_out,       // 1: switch before scan
  output logic gate_scan_dir_out,             // 1: scan up
  output logic source_shift_dir_out,          // 1: shift right
  output logic booster_on_out,                // booster enable
  output logic waveform_source_sel_out,       // 1: waveform from regs
  output logic common_electrode_voltage_out,  // common rail on
  output logic source_drive_voltages_out,     // source rails on
  output logic gate_drive_voltages_out        // gate rails on
);
  localparam int STEP_W = $clog2(POWER_STEP_CYCLES + 1);
  localparam int NSYNC = 6;
  localparam int S_SCLK = 0;
  localparam int S_CS = 1;
  localparam int S_DC = 2;
  localparam int S_SDA = 3;
  localparam int S_RST = 4;
  localparam int S_BUS = 5;

  typedef enum logic [3:0] {
    PW_ON = 4'b0001,
    PW_DROP_SRC = 4'b0010,
    PW_DROP_GATE = 4'b0100,
    PW_OFF = 4'b1000
  } power_state_t;

  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] pins;
  logic sclk_prev_q;
  logic sclk_s, cs_n_s, dc_s, sda_s, three_wire, dev_rst;
  logic rise, fall, last_bit, byte_done, is_data, read_phase, drive_upd;
  logic [3:0] frame_bits;
  logic [3:0] bit_cnt_q;
  logic [3:0] pay_cnt;
  logic [7:0] shift_q;
  logic [7:0] rx_byte;
  logic flag3_q;
  logic [7:0] cmd_q;
  logic [1:0] param_idx_q;
  logic [7:0] first_q;
  logic [7:0] second_q;
  logic [7:0] rd_byte_q;
  logic [7:0] rd_sel;
  logic sda_out_q;
  logic sda_oe_n_q;
  logic valid_q;
  logic [7:0] byte_q;
  logic data_q;
  power_state_t pw_q;
  logic [STEP_W-1:0] step_q;
  logic [2:0] rails_q;
  logic busy_n_q;

  assign pins = {link.bus_select, link.reset_n, link.sda, link.dc,
                 link.cs_n, link.sclk};

  // two-stage synchronisers for every pin
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sclk_prev_q <= 1'b0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sclk_prev_q <= sync2_q[S_SCLK];
    end
  end

  assign sclk_s = sync2_q[S_SCLK];
  assign cs_n_s = sync2_q[S_CS];
  assign dc_s = sync2_q[S_DC];
  assign sda_s = sync2_q[S_SDA];
  assign three_wire = sync2_q[S_BUS];                 // [R6] [R7]
  assign dev_rst = !rst_n_in || !sync2_q[S_RST];      // [R3]
  assign rise = sclk_s && !sclk_prev_q;               // [R8]
  assign fall = !sclk_s && sclk_prev_q;
  assign frame_bits = three_wire ? BITS_3WIRE : BITS_4WIRE; // [R6]
  assign last_bit = bit_cnt_q == frame_bits - 4'h1;
  assign byte_done = !cs_n_s && rise && last_bit;     // [R1]
  assign rx_byte = {shift_q[6:0], sda_s};             // [R21] [R19]
  assign is_data = three_wire ? flag3_q : dc_s;       // [R2] [R19]
  assign pay_cnt = (three_wire && bit_cnt_q != 4'h0) ?
                   bit_cnt_q - 4'h1 : bit_cnt_q;
  assign rd_sel = rd_byte_q << pay_cnt[2:0];

  // bit counter and shifter; the counter clears whenever chip select is high, the shifter keeps its value
  always_ff @(posedge core_clk_in) begin
    if (dev_rst) begin
      bit_cnt_q <= '0;
      shift_q <= '0;
      flag3_q <= 1'b0;
    end else if (cs_n_s) begin                         // [R1]
      bit_cnt_q <= '0;
    end else if (rise) begin                           // [R8]
      shift_q <= rx_byte;
      bit_cnt_q <= last_bit ? 4'h0 : bit_cnt_q + 4'h1;
      if (three_wire && bit_cnt_q == 4'h0) begin
        flag3_q <= sda_s;                              // [R19]
      end
    end
  end

  // command tracking and parameter capture
  always_ff @(posedge core_clk_in) begin
    if (dev_rst) begin
      cmd_q <= CMD_NONE;
      param_idx_q <= PARAM_FIRST;
      first_q <= PANEL_FIRST_RESET;                    // [R11]
      second_q <= PANEL_SECOND_RESET;                  // [R11]
    end else if (byte_done) begin
      if (!is_data) begin                              // [R2]
        cmd_q <= rx_byte;
        param_idx_q <= PARAM_FIRST;                    // [R20]
      end else begin
        if (cmd_q == CMD_PANEL_SETTING) begin          // [R11]
          if (param_idx_q == PARAM_FIRST) begin
            first_q <= rx_byte;                        // [R20]
          end else if (param_idx_q == PARAM_SECOND) begin
            second_q <= rx_byte;                       // [R20]
          end
        end
        if (param_idx_q != PARAM_BEYOND) begin
          param_idx_q <= param_idx_q + 2'h1;
        end
      end
    end
  end

  // received byte report
  always_ff @(posedge core_clk_in) begin
    if (dev_rst) begin
      valid_q <= 1'b0;
      byte_q <= '0;
      data_q <= 1'b0;
    end else begin
      valid_q <= byte_done;
      if (byte_done) begin
        byte_q <= rx_byte;
        data_q <= is_data;
      end
    end
  end

  // read return: data bits change on falling serial clock edges, and while the clock is low at bit count zero
  assign read_phase = !cs_n_s && cmd_q == READ_CMD &&
                      (three_wire ? (bit_cnt_q != 4'h0 && flag3_q) : dc_s);
  assign drive_upd = fall || (bit_cnt_q == 4'h0 && !sclk_s);

  always_ff @(posedge core_clk_in) begin
    if (dev_rst) begin
      rd_byte_q <= '0;
      sda_out_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else begin
      if (bit_cnt_q == 4'h0 && !rise) begin
        rd_byte_q <= rd_byte_in;
      end
      if (cs_n_s) begin
        sda_oe_n_q <= 1'b1;                            // [R1]
      end else if (drive_upd) begin
        sda_oe_n_q <= !read_phase;                     // [R9]
        sda_out_q <= rd_sel[7];                        // [R9]
      end
    end
  end

  // power-off sequencer
  always_ff @(posedge core_clk_in) begin
    if (dev_rst) begin
      pw_q <= PW_OFF;
      step_q <= '0;
    end else begin
      case (pw_q)
        PW_ON: begin
          if (power_down_in) begin
            pw_q <= PW_DROP_SRC;                       // [R10]
            step_q <= STEP_W'(POWER_STEP_CYCLES - 1);
          end
        end
        PW_DROP_SRC: begin
          if (step_q == '0) begin
            pw_q <= PW_DROP_GATE;                      // [R10]
            step_q <= STEP_W'(POWER_STEP_CYCLES - 1);
          end else begin
            step_q <= step_q - 1'b1;
          end
        end
        PW_DROP_GATE: begin
          if (step_q == '0) begin
            pw_q <= PW_OFF;                            // [R10]
          end else begin
            step_q <= step_q - 1'b1;
          end
        end
        PW_OFF: begin
          if (power_up_in) begin
            pw_q <= PW_ON;
          end
        end
        default: pw_q <= PW_OFF;
      endcase
    end
  end

  // rail enables: common, source, gate
  always_ff @(posedge core_clk_in) begin
    if (dev_rst) begin
      rails_q <= 3'h0;
      busy_n_q <= 1'b1;
    end else begin
      rails_q[0] <= pw_q == PW_ON;                              // [R10]
      rails_q[1] <= pw_q == PW_ON || pw_q == PW_DROP_SRC;       // [R10]
      rails_q[2] <= pw_q != PW_OFF;                             // [R10]
      busy_n_q <= !(waveform_active_in || sensor_active_in ||
                    pw_q == PW_DROP_SRC || pw_q == PW_DROP_GATE); // [R5]
    end
  end

  assign link.dev_sda_out = sda_out_q;
  assign link.dev_sda_oe_n = sda_oe_n_q;
  assign link.busy_n = busy_n_q;
  assign byte_valid_out = valid_q;
  assign byte_out = byte_q;
  assign byte_is_data_out = data_q;
  assign command_out = cmd_q;
  assign panel_first_out = first_q;
  assign panel_second_out = second_q;
  assign resolution_sel_out = first_q[RES_HI_BIT:RES_LO_BIT];           // [R12]
  assign gate_lines_out = first_q[RES_HI_BIT] ? LINES_128 : LINES_200;  // [R12]
  assign source_lines_out = first_q[RES_LO_BIT] ? LINES_128 : LINES_200;
  assign power_switch_timing_out = first_q[POWER_SWITCH_BIT];           // [R13]
  assign gate_scan_dir_out = first_q[GATE_DIR_BIT];                 // [R14] [R15]
  assign source_shift_dir_out = first_q[SOURCE_DIR_BIT];            // [R16]
  assign booster_on_out = first_q[BOOSTER_BIT];                     // [R17]
  assign waveform_source_sel_out = second_q[WAVE_SRC_BIT];          // [R18]
  assign common_electrode_voltage_out = rails_q[0];
  assign source_drive_voltages_out = rails_q[1];
  assign gate_drive_voltages_out = rails_q[2];
endmodule

// ### common/epd_link_pkg.sv
// constants shared by both ends of the panel serial link
package epd_link_pkg;
  localparam int CORE_CLK_HZ = 20_000_000;
  localparam int POWER_OFF_STEP_MS = 20;
  localparam int POWER_OFF_STEP_CYCLES = POWER_OFF_STEP_MS * (CORE_CLK_HZ / 1000);

  localparam logic [7:0] CMD_PANEL_SETTING = 8'h00;
  localparam logic [7:0] CMD_READ_DEFAULT = 8'h11;
  localparam logic [7:0] CMD_NONE = 8'hff;
  localparam logic [7:0] PANEL_FIRST_RESET = 8'h0f;
  localparam logic [7:0] PANEL_SECOND_RESET = 8'h09;
  localparam logic [1:0] PARAM_FIRST = 2'h0;
  localparam logic [1:0] PARAM_SECOND = 2'h1;
  localparam logic [1:0] PARAM_BEYOND = 2'h2;

  localparam int RES_HI_BIT = 7;
  localparam int RES_LO_BIT = 6;
  localparam int POWER_SWITCH_BIT = 5;
  localparam int GATE_DIR_BIT = 3;
  localparam int SOURCE_DIR_BIT = 2;
  localparam int BOOSTER_BIT = 1;
  localparam int WAVE_SRC_BIT = 7;
  localparam logic [7:0] LINES_200 = 8'hc8;
  localparam logic [7:0] LINES_128 = 8'h80;

  localparam logic [3:0] BITS_4WIRE = 4'h8;
  localparam logic [3:0] BITS_3WIRE = 4'h9;

  // host controller registers, byte addresses on apb
  localparam logic [11:0] REG_TX = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CONFIG = 12'h008;
  localparam logic [11:0] REG_DIV = 12'h00c;
  localparam int TX_DC_BIT = 8;
  localparam int TX_READ_BIT = 9;
  localparam int CFG_THREE_WIRE_BIT = 0;
  localparam int CFG_RESET_BIT = 1;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_RX_LSB = 8;
  localparam logic [1:0] CONFIG_RESET = 2'h2;
  localparam logic [15:0] DIV_RESET = 16'h0004;
endpackage

// ### common/epd_link_if.sv
// serial command link between host and panel controller
`timescale 1ns/1ps
interface epd_link_if;
  logic cs_n;
  logic dc;
  logic sclk;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic sda;
  logic reset_n;
  logic bus_select;
  logic busy_n;

  // shared data wire, pulled up when nobody drives
  assign sda = !host_sda_oe_n ? host_sda_out :
               (!dev_sda_oe_n ? dev_sda_out : 1'b1);

  modport device (
    input cs_n, dc, sclk, sda, reset_n, bus_select,
    output dev_sda_out, dev_sda_oe_n, busy_n
  );
  modport host (
    output cs_n, dc, sclk, host_sda_out, host_sda_oe_n, reset_n, bus_select,
    input sda, busy_n
  );
endinterface

// ### logic/epd_link_host.sv
// host end: apb-controlled serial byte sender and reader
`timescale 1ns/1ps
module epd_link_host
  import epd_link_pkg::*;
(
  input wire logic core_clk_in,        // core clock
  input wire logic rst_n_in,           // sync reset, active low
  input wire logic psel_in,            // apb select
  input wire logic penable_in,         // apb enable
  input wire logic pwrite_in,          // apb direction
  input wire logic [11:0] paddr_in,    // apb byte address
  input wire logic [31:0] pwdata_in,   // apb write data
  output logic [31:0] prdata_out,      // apb read data
  output logic pready_out,             // apb ready
  output logic pslverr_out,            // apb error
  output logic done_out,               // transfer finished, pulse
  epd_link_if.host link                // serial link pins
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_WAIT = 6'b000010,
    H_SEL = 6'b000100,
    H_LOW = 6'b001000,
    H_HIGH = 6'b010000,
    H_END = 6'b100000
  } host_state_t;

  host_state_t st_q;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic busy_n_s, sda_s;
  logic [1:0] cfg_q;
  logic [15:0] div_q;
  logic [9:0] tx_q;
  logic go_q;
  logic [8:0] shift_q;
  logic [3:0] sent_q;
  logic [3:0] nbits;
  logic [15:0] half_q;
  logic half_end, payload, setup, acc_wr, tx_hit, bad_addr;
  logic [7:0] rx_q;
  logic [31:0] rdata_q;
  logic cs_n_q, sclk_q, sda_q, oe_n_q, dc_q, done_q;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sync1_q <= 2'h3;
      sync2_q <= 2'h3;
    end else begin
      sync1_q <= {link.sda, link.busy_n};
      sync2_q <= sync1_q;
    end
  end
  assign busy_n_s = sync2_q[0];
  assign sda_s = sync2_q[1];

  // apb slave, zero wait states
  assign setup = psel_in && !penable_in;
  assign acc_wr = psel_in && penable_in && pwrite_in;
  assign tx_hit = paddr_in == REG_TX;
  assign bad_addr = !(tx_hit || paddr_in == REG_STATUS ||
                      paddr_in == REG_CONFIG || paddr_in == REG_DIV);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in &&
                       (bad_addr || (pwrite_in && tx_hit && st_q != H_IDLE));
  assign prdata_out = rdata_q;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= '0;
    end else if (setup && !pwrite_in) begin
      rdata_q <= '0;
      if (paddr_in == REG_STATUS) begin
        rdata_q[STAT_ACTIVE_BIT] <= st_q != H_IDLE;
        rdata_q[STAT_BUSY_BIT] <= !busy_n_s;
        rdata_q[STAT_RX_LSB +: 8] <= rx_q;
      end else if (paddr_in == REG_CONFIG) begin
        rdata_q[1:0] <= cfg_q;
      end else if (paddr_in == REG_DIV) begin
        rdata_q[15:0] <= div_q;
      end else if (tx_hit) begin
        rdata_q[9:0] <= tx_q;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cfg_q <= CONFIG_RESET;
      div_q <= DIV_RESET;
      tx_q <= '0;
      go_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (acc_wr && paddr_in == REG_CONFIG) begin
        cfg_q <= pwdata_in[1:0];
      end
      if (acc_wr && paddr_in == REG_DIV) begin
        div_q <= pwdata_in[15:0];
      end
      if (acc_wr && tx_hit && st_q == H_IDLE) begin
        tx_q <= pwdata_in[9:0];
        go_q <= 1'b1;
      end
    end
  end

  // serial engine: clock idles low, data changes while clock is low
  assign nbits = cfg_q[CFG_THREE_WIRE_BIT] ? BITS_3WIRE : BITS_4WIRE;
  assign half_end = half_q == div_q - 16'h1;
  assign payload = tx_q[TX_READ_BIT] &&
                   (!cfg_q[CFG_THREE_WIRE_BIT] || sent_q != 4'h0);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_q <= H_IDLE;
      half_q <= '0;
      shift_q <= '0;
      sent_q <= '0;
      rx_q <= '0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      sda_q <= 1'b1;
      oe_n_q <= 1'b1;
      dc_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      half_q <= half_end ? 16'h0 : half_q + 16'h1;
      case (st_q)
        H_IDLE: begin
          half_q <= '0;
          if (go_q) begin
            st_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          half_q <= '0;
          if (busy_n_s) begin                          // [R4]
            st_q <= H_SEL;
            cs_n_q <= 1'b0;                            // [R1] [R2]
            dc_q <= cfg_q[CFG_THREE_WIRE_BIT] ? 1'b0 : tx_q[TX_DC_BIT];
            shift_q <= cfg_q[CFG_THREE_WIRE_BIT] ?     // [R19] [R21]
                       tx_q[8:0] : {tx_q[7:0], 1'b0};
            sent_q <= '0;
          end
        end
        H_SEL: begin
          if (half_end) begin
            st_q <= H_LOW;
            sda_q <= shift_q[8];
            oe_n_q <= payload;
          end
        end
        H_LOW: begin
          if (half_end) begin
            st_q <= H_HIGH;
            sclk_q <= 1'b1;
          end
        end
        H_HIGH: begin
          if (half_end) begin
            sclk_q <= 1'b0;
            if (payload) begin
              rx_q <= {rx_q[6:0], sda_s};
            end
            shift_q <= {shift_q[7:0], 1'b0};
            sent_q <= sent_q + 4'h1;
            if (sent_q == nbits - 4'h1) begin
              st_q <= H_END;
              oe_n_q <= 1'b1;
            end else begin
              st_q <= H_LOW;
              sda_q <= shift_q[7];                     // [R8]
              oe_n_q <= tx_q[TX_READ_BIT];
            end
          end
        end
        H_END: begin
          if (half_end) begin
            st_q <= H_IDLE;
            cs_n_q <= 1'b1;
            done_q <= 1'b1;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.dc = dc_q;
  assign link.host_sda_out = sda_q;
  assign link.host_sda_oe_n = oe_n_q;
  assign link.reset_n = cfg_q[CFG_RESET_BIT];
  assign link.bus_select = cfg_q[CFG_THREE_WIRE_BIT];
  assign done_out = done_q;
endmodule

// ### verif/epd_link_checker.sv
// concurrent checks on the serial link wires between the two ends
`timescale 1ns/1ps
module epd_link_checker (
  input wire logic core_clk_in,   // core clock
  input wire logic rst_n_in,      // sync reset, active low
  input wire logic cs_n,          // chip select
  input wire logic dc,            // data or command level
  input wire logic sclk,          // serial clock
  input wire logic host_sda_oe_n, // host drives data when low
  input wire logic dev_sda_oe_n,  // device drives data when low
  input wire logic bus_select,    // wire mode pin
  input wire logic busy_n         // device busy when low
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic sc_q;
  logic [3:0] n_q;
  always_ff @(posedge core_clk_in) begin
    sc_q <= sclk;
  end
  // rising serial clock edges in the current frame
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || cs_n) n_q <= 4'h0;
    else if (sclk && !sc_q) n_q <= n_q + 4'h1;
  end
  idle_clock_a: assert property (cs_n |-> !sclk)
    else $error("serial clock moved while deselected");
  dev_quiet_a: assert property (cs_n [*8] |-> dev_sda_oe_n)
    else $error("device drives data while deselected");
  lead_in_a: assert property ($fell(cs_n) |-> !sclk [*4])
    else $error("clock rose too soon after select");
  one_driver_a: assert property (host_sda_oe_n || dev_sda_oe_n)
    else $error("both ends drive the data wire");
  busy_start_a: assert property ($fell(cs_n) |-> $past(busy_n))
    else $error("frame started while device busy");
  dc_hold_a: assert property (!cs_n && !$past(cs_n) |-> $stable(dc))
    else $error("select pin changed inside a frame");
  flag_low_a: assert property (!cs_n && bus_select |-> !dc)
    else $error("select pin not low in three wire mode");
  high_half_a: assert property ($rose(sclk) |-> sclk [*4])
    else $error("serial clock high phase too short");
  bit_count_a: assert property ($rose(cs_n) |->
    n_q == (bus_select ? 4'h9 : 4'h8))
    else $error("wrong bit count in frame");
endmodule

// ### verif/epaper_serial_host_interface_tb_top.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
module epaper_serial_host_interface_tb_top;
  import epd_link_pkg::*;
  localparam int STEP = 8;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic wav = 1'b0, sen = 1'b0, pdn = 1'b0, pup = 1'b0, tw = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pw = 32'h0000_0000, prd, rdat;
  logic [7:0] rdb = 8'h00, bo, cmd, pf, ps, gl, sl;
  logic [1:0] rs;
  logic bv, bd, pr, pe, done, err, pst, gd, sd, bon, wsel, cv, sv, gv;
  logic skip = 1'b0, sc_q = 1'b0, cs_q = 1'b1;
  logic [8:0] wexp = 9'h000, wsh = 9'h000;
  logic [8:0] exq[$];
  int n_fail = 0, checks = 0, mf = 15, ms = 9, mc = 255, mi = 0;
  epd_link_if lnk();
  epd_link_device #(.POWER_STEP_CYCLES(STEP)) i_epd_link_device (
    .core_clk_in(clk), .rst_n_in(rst_n), .link(lnk),
    .waveform_active_in(wav), .sensor_active_in(sen),
    .power_down_in(pdn), .power_up_in(pup), .rd_byte_in(rdb),
    .byte_valid_out(bv), .byte_out(bo), .byte_is_data_out(bd),
    .command_out(cmd), .panel_first_out(pf), .panel_second_out(ps),
    .resolution_sel_out(rs), .gate_lines_out(gl), .source_lines_out(sl),
    .power_switch_timing_out(pst), .gate_scan_dir_out(gd),
    .source_shift_dir_out(sd), .booster_on_out(bon),
    .waveform_source_sel_out(wsel), .common_electrode_voltage_out(cv),
    .source_drive_voltages_out(sv), .gate_drive_voltages_out(gv));
  epd_link_host i_epd_link_host (
    .core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pw), .prdata_out(prd),
    .pready_out(pr), .pslverr_out(pe), .done_out(done), .link(lnk));
  epd_link_checker u_chk (
    .core_clk_in(clk), .rst_n_in(rst_n), .cs_n(lnk.cs_n), .dc(lnk.dc),
    .sclk(lnk.sclk), .host_sda_oe_n(lnk.host_sda_oe_n),
    .dev_sda_oe_n(lnk.dev_sda_oe_n), .bus_select(lnk.bus_select),
    .busy_n(lnk.busy_n));
  initial forever #25 clk = ~clk;
  task close_out;
    $display("mismatches %0d checks %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task tmo;
    n_fail++;
    $display("BAD %0t wait ran out", $time);
    close_out();
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pw <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) tmo();
    end while (pr !== 1'b1);
    rdat = prd;
    err = pe;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // one byte frame; the model follows the command and parameter order
  task send(input logic f, input logic [7:0] b, input logic r);
    int n;
    skip = r;
    if (!r) exq.push_back({f, b});
    apb(1'b1, REG_TX, {22'h0, r, f, b});
    // read byte comes by nba just before the call, so take it late
    wexp = {tw & f, r ? rdb : b};
    n = 0;
    while (done !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 3000) tmo();
    end
    skip = 1'b0;
    if (r) begin
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      cmp(rdat[15:8], rdb);
    end else if (!f) begin
      mc = b;
      mi = 0;
    end else if (mc == 0) begin
      if (mi == 0) mf = b;
      if (mi == 1) ms = b;
      mi++;
    end
  endtask
  task chkp;
    cmp(pf, mf);
    cmp(ps, ms);
    cmp(cmd, mc);
    cmp(rs, mf[7:6]);
    cmp(gl, mf[7] ? LINES_128 : LINES_200);
    cmp(sl, mf[6] ? LINES_128 : LINES_200);
    cmp({pst, gd, sd, bon}, {mf[5], mf[3:1]});
    cmp(wsel, ms[7]);
  endtask
  task wrail(input logic [2:0] p, output int n);
    n = 0;
    while ({cv, sv, gv} !== p) begin
      @(posedge clk);
      n++;
      if (n > 100) tmo();
    end
  endtask
  // wire order and received byte monitors
  always @(posedge clk) begin
    sc_q <= lnk.sclk;
    cs_q <= lnk.cs_n;
    if (!lnk.cs_n && lnk.sclk && !sc_q) wsh <= {wsh[7:0], lnk.sda};
    if (lnk.cs_n && !cs_q) begin
      cmp(wsh, wexp);
      wsh <= 9'h000;
    end
    if (bv === 1'b1 && !skip) begin
      if (exq.size() == 0) cmp(1, 0);
      else cmp({bd, bo}, exq.pop_front());
    end
  end
  initial begin
    int n;
    logic [7:0] p1;
    n = $urandom(32'h8fb4_9958);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chkp();
    apb(1'b0, REG_CONFIG, 32'h0000_0000);
    cmp(rdat, CONFIG_RESET);
    apb(1'b0, REG_DIV, 32'h0000_0000);
    cmp(rdat, DIV_RESET);
    apb(1'b0, 12'h010, 32'h0000_0000);
    cmp(err, 1'b1);
    cmp(rdat, 32'h0000_0000);
    for (int m = 0; m < 4; m++) begin
      tw = m[0];
      apb(1'b1, REG_CONFIG, {30'h0, 1'b1, m[0]});
      {sen, wav} <= m[0] ? 2'b10 : 2'b01;
      repeat (4) @(posedge clk);
      cmp(lnk.busy_n, 0);
      fork
        begin
          repeat (30) @(posedge clk);
          cmp(lnk.cs_n, 1);
          {sen, wav} <= 2'b00;
        end
        send(1'b0, CMD_PANEL_SETTING, 1'b0);
      join
      p1 = {m[1:0], 6'($urandom)};
      send(1'b1, p1, 1'b0);
      send(1'b1, 8'($urandom), 1'b0);
      send(1'b1, 8'($urandom), 1'b0);
      chkp();
      send(1'b0, CMD_READ_DEFAULT, 1'b0);
      rdb <= 8'($urandom);
      send(1'b1, 8'h00, 1'b1);
    end
    apb(1'b1, REG_CONFIG, 32'h0000_0000);
    repeat (8) @(posedge clk);
    mf = 15;
    ms = 9;
    mc = 255;
    chkp();
    apb(1'b1, REG_CONFIG, 32'h0000_0002);
    // panel reset pin passes two flops before the device leaves reset
    repeat (4) @(posedge clk);
    pup <= 1'b1;
    @(posedge clk);
    pup <= 1'b0;
    wrail(3'b111, n);
    pdn <= 1'b1;
    @(posedge clk);
    pdn <= 1'b0;
    wrail(3'b011, n);
    @(posedge clk);
    cmp(lnk.busy_n, 0);
    wrail(3'b001, n);
    cmp(n >= STEP - 2, 1);
    wrail(3'b000, n);
    cmp(n >= STEP - 2, 1);
    close_out();
  end
endmodule
